//--- rtl/ldm_pkg.sv
// shared constants and carriers of the led driver mode and config registers
package ldm_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE   = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_IEN    = 8'h03;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_SINK   = 8'h05;
    localparam logic [7:0] MASK_MODE   = 8'h7f;
    localparam logic [7:0] MASK_FLAGS  = 8'h1f;
    localparam logic [7:0] MASK_CFG    = 8'h7f;
    localparam logic [7:0] MASK_SINK   = 8'h7f;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_INT_STYLE = 6;
    localparam int BIT_ACTIVE    = 5;
    localparam int BIT_DIM       = 4;
    localparam int BIT_GAIN_BLK  = 3;
    localparam int BIT_GROUP_SW  = 2;
    localparam int BIT_AUTO      = 1;
    localparam int BIT_BL_ON     = 0;
    localparam int BIT_SRC_SEL   = 6;
    localparam int BIT_B_PRESENT = 5;
    localparam int BIT_LVL_LO    = 3;
    localparam int BIT_LAW_LO    = 1;
    localparam int BIT_FADE_OVR  = 0;
    localparam int DIODE6_IDX    = 5;
    localparam logic [1:0] LVL_DAY    = 2'h0;
    localparam logic [1:0] LVL_OFFICE = 2'h1;
    localparam logic [1:0] LVL_DARK   = 2'h2;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 40000000;
    localparam int RELEASE_US    = 50;
    localparam int RELEASE_CYC   = CLK_HZ / 1000000 * RELEASE_US;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ldm_hostreq_s;
    typedef struct packed {
        logic       shortEvt;
        logic       overheatEvt;
        logic       overvoltageEvt;
        logic       sensorBEvt;
        logic       sensorAEvt;
    } ldm_events_s;
    typedef enum logic [2:0] {
        IRQ_IDLE   = 3'b001,
        IRQ_ASSERT = 3'b010,
        IRQ_HOLD   = 3'b100
    } ldm_irq_e;
endpackage : ldm_pkg

//--- rtl/ldm_flag_bit.sv
// one sticky write-one-to-clear status flag
`timescale 1ns/1ps
module ldm_flag_bit
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic setEvt,
    input  wire logic clearOne,
    output logic      flag
);
    // ----------------------------------------------------------------
    // flag store, set beats clear
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            flag <= 1'b0;
        else if (setEvt)
            flag <= 1'b1;
        else if (clearOne)
            flag <= 1'b0;
    end
endmodule : ldm_flag_bit

//--- rtl/ldm_release_timer.sv
// interrupt release window counter
`timescale 1ns/1ps
module ldm_release_timer
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic start,
    output logic      busy
);
    logic [11:0] count_r;
    // ----------------------------------------------------------------
    // count down the release window
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            count_r <= 12'h000;
        else if (start)
            count_r <= 12'(ldm_pkg::RELEASE_CYC);
        else if (count_r != 12'h000)
            count_r <= count_r - 12'h001;
    end
    assign busy = (count_r != 12'h000);
endmodule : ldm_release_timer

//--- rtl/ldm_regs.sv
// mode, interrupt, configuration and sink assignment register bank
`timescale 1ns/1ps
module ldm_regs
(
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 uvloEvt,
    input  ldm_pkg::ldm_hostreq_s     hostReq,
    output logic [7:0]                rdata,
    input  ldm_pkg::ldm_events_s      events,
    input  wire logic                 dimTimeout,
    input  wire logic                 officeLevelCompareOn,
    input  wire logic                 darkLevelCompareOn,
    input  wire logic                 officeLevelCompareResult,
    input  wire logic                 darkLevelCompareResult,
    input  wire logic [6:0]           perSinkEnable,
    input  wire logic                 ledsAllOff,
    input  wire logic                 pumpNeedUp,
    input  wire logic                 pumpCanDown,
    output logic                      hostIntN,
    output logic                      activeNotSleep,
    output logic                      backlightRun,
    output logic                      dimRun,
    output logic                      pumpUp,
    output logic                      pumpDown,
    output logic [6:0]                groupSinkRun,
    output logic [6:0]                diodeIndependent,
    output logic                      sensorSourceSelect,
    output logic                      sensorBPresent,
    output logic                      diode6Disable,
    output logic [1:0]                brightnessLevel,
    output logic [1:0]                transferLaw,
    output logic                      fadeOverride
);
    logic [7:0] mode_r;
    logic [7:0] ien_r;
    logic [7:0] cfg_r;
    logic [7:0] sink_r;
    logic [4:0] flags;
    logic [4:0] setVec;
    logic [4:0] clrVec;
    logic       clrRst;
    logic       wrStatus;
    logic       pending;
    logic       relBusy;
    logic       autoOn;
    logic [1:0] autoLvl;
    ldm_pkg::ldm_irq_e irqState_r;
    ldm_pkg::ldm_irq_e irqState_nxt;

    assign clrRst   = reset | uvloEvt;
    assign autoOn   = mode_r[ldm_pkg::BIT_AUTO]
                    & (officeLevelCompareOn | darkLevelCompareOn);
    assign autoLvl  = (darkLevelCompareOn & darkLevelCompareResult)
                    ? ldm_pkg::LVL_DARK
                    : (officeLevelCompareOn & officeLevelCompareResult)
                    ? ldm_pkg::LVL_OFFICE : ldm_pkg::LVL_DAY;
    assign wrStatus = hostReq.wrEn & (hostReq.addr == ldm_pkg::ADDR_STATUS);
    // ----------------------------------------------------------------
    // host writable registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mode_r <= ldm_pkg::RESET_VALUE;
            ien_r  <= ldm_pkg::RESET_VALUE;
            sink_r <= ldm_pkg::RESET_VALUE;
        end
        else if (uvloEvt)
        begin
            mode_r <= ldm_pkg::RESET_VALUE;
            ien_r  <= ldm_pkg::RESET_VALUE;
            sink_r <= ldm_pkg::RESET_VALUE;
        end
        else
        begin
            if (hostReq.wrEn && hostReq.addr == ldm_pkg::ADDR_MODE)
                mode_r <= hostReq.wdata & ldm_pkg::MASK_MODE;
            if (hostReq.wrEn && hostReq.addr == ldm_pkg::ADDR_IEN)
                ien_r <= hostReq.wdata & ldm_pkg::MASK_FLAGS;
            if (hostReq.wrEn && hostReq.addr == ldm_pkg::ADDR_SINK)
                sink_r <= hostReq.wdata & ldm_pkg::MASK_SINK;
            if (dimTimeout)
                mode_r[ldm_pkg::BIT_DIM] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            cfg_r <= ldm_pkg::RESET_VALUE;
        else if (uvloEvt)
            cfg_r <= ldm_pkg::RESET_VALUE;
        else
        begin
            if (hostReq.wrEn && hostReq.addr == ldm_pkg::ADDR_CFG)
                cfg_r <= hostReq.wdata & ldm_pkg::MASK_CFG;
            if (autoOn)
                cfg_r[ldm_pkg::BIT_LVL_LO +: 2] <= autoLvl;
        end
    end
    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    assign setVec = {events.shortEvt, events.overheatEvt,
                     events.overvoltageEvt, events.sensorBEvt,
                     events.sensorAEvt};
    assign clrVec = wrStatus ? hostReq.wdata[4:0] : 5'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_flag
            ldm_flag_bit u_flag
            (
                .mclk     (mclk),
                .reset    (clrRst),
                .setEvt   (setVec[gi]),
                .clearOne (clrVec[gi]),
                .flag     (flags[gi])
            );
        end
    endgenerate
    // ----------------------------------------------------------------
    // host interrupt sequencing
    // ----------------------------------------------------------------
    assign pending = |(flags & ien_r[4:0]);

    ldm_release_timer u_rel
    (
        .mclk  (mclk),
        .reset (clrRst),
        .start (wrStatus & mode_r[ldm_pkg::BIT_INT_STYLE]),
        .busy  (relBusy)
    );

    always_comb
    begin
        irqState_nxt = irqState_r;
        case (irqState_r)
            ldm_pkg::IRQ_IDLE:
                if (pending && !relBusy)
                    irqState_nxt = ldm_pkg::IRQ_ASSERT;
            ldm_pkg::IRQ_ASSERT:
                if (relBusy)
                    irqState_nxt = ldm_pkg::IRQ_HOLD;
                else if (!pending)
                    irqState_nxt = ldm_pkg::IRQ_IDLE;
            ldm_pkg::IRQ_HOLD:
                if (!relBusy)
                    irqState_nxt = ldm_pkg::IRQ_IDLE;
            default:
                irqState_nxt = ldm_pkg::IRQ_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            irqState_r <= ldm_pkg::IRQ_IDLE;
        else if (uvloEvt)
            irqState_r <= ldm_pkg::IRQ_IDLE;
        else
            irqState_r <= irqState_nxt;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            hostIntN <= 1'b1;
        else
            hostIntN <= !(irqState_nxt == ldm_pkg::IRQ_ASSERT);
    end
    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
            rdata <= 8'h00;
        else if (hostReq.rdEn)
            case (hostReq.addr)
                ldm_pkg::ADDR_MODE:   rdata <= mode_r;
                ldm_pkg::ADDR_STATUS: rdata <= {3'h0, flags};
                ldm_pkg::ADDR_IEN:    rdata <= ien_r;
                ldm_pkg::ADDR_CFG:    rdata <= cfg_r;
                ldm_pkg::ADDR_SINK:   rdata <= sink_r;
                default:              rdata <= 8'h00;
            endcase
    end
    // ----------------------------------------------------------------
    // controls to the analog and timing blocks
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            activeNotSleep     <= 1'b0;
            backlightRun       <= 1'b0;
            dimRun             <= 1'b0;
            pumpUp             <= 1'b0;
            pumpDown           <= 1'b0;
            groupSinkRun       <= 7'h00;
            diodeIndependent   <= 7'h00;
            sensorSourceSelect <= 1'b0;
            sensorBPresent     <= 1'b0;
            diode6Disable      <= 1'b0;
            brightnessLevel    <= 2'h0;
            transferLaw        <= 2'h0;
            fadeOverride       <= 1'b0;
        end
        else
        begin
            activeNotSleep <= mode_r[ldm_pkg::BIT_ACTIVE];
            backlightRun   <= mode_r[ldm_pkg::BIT_BL_ON]
                            & mode_r[ldm_pkg::BIT_ACTIVE];
            dimRun         <= mode_r[ldm_pkg::BIT_DIM]
                            & mode_r[ldm_pkg::BIT_BL_ON]
                            & mode_r[ldm_pkg::BIT_ACTIVE];
            pumpUp         <= pumpNeedUp & mode_r[ldm_pkg::BIT_ACTIVE];
            pumpDown       <= pumpCanDown
                            & (!mode_r[ldm_pkg::BIT_GAIN_BLK]
                               | ledsAllOff);
            groupSinkRun   <= (perSinkEnable == 7'h00
                               && mode_r[ldm_pkg::BIT_GROUP_SW]
                               && mode_r[ldm_pkg::BIT_ACTIVE])
                            ? sink_r[6:0] : 7'h00;
            diodeIndependent   <= sink_r[6:0];
            sensorSourceSelect <= cfg_r[ldm_pkg::BIT_SRC_SEL];
            sensorBPresent     <= cfg_r[ldm_pkg::BIT_B_PRESENT];
            diode6Disable      <= cfg_r[ldm_pkg::BIT_B_PRESENT];
            brightnessLevel    <= cfg_r[ldm_pkg::BIT_LVL_LO +: 2];
            transferLaw        <= cfg_r[ldm_pkg::BIT_LAW_LO +: 2];
            fadeOverride       <= cfg_r[ldm_pkg::BIT_FADE_OVR];
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_clear_styled;
        wrStatus && mode_r[ldm_pkg::BIT_INT_STYLE];
    endsequence

    a_release_window: assert property (@(posedge mclk) disable iff (clrRst)
        s_clear_styled |=> ##1 hostIntN[*8])
        else $error("interrupt not released after clear");
    a_steady_irq: assert property (@(posedge mclk) disable iff (clrRst)
        (wrStatus && !mode_r[ldm_pkg::BIT_INT_STYLE] && !relBusy
         && |(flags & ien_r[4:0] & (~clrVec | setVec)))
        |=> ##1 !hostIntN)
        else $error("interrupt dropped with pending event");
    a_active_follow: assert property (@(posedge mclk) disable iff (clrRst)
        ##1 activeNotSleep == $past(mode_r[ldm_pkg::BIT_ACTIVE]))
        else $error("active mode output wrong");
    a_dim_gate: assert property (@(posedge mclk) disable iff (clrRst)
        dimRun |-> backlightRun)
        else $error("dim without backlight");
    a_gain_hold: assert property (@(posedge mclk) disable iff (clrRst)
        (mode_r[ldm_pkg::BIT_GAIN_BLK] && !ledsAllOff
         && $stable(mode_r)) |=> !pumpDown)
        else $error("pump gain lowered while blocked");
    a_group_block: assert property (@(posedge mclk) disable iff (clrRst)
        (perSinkEnable != 7'h00) |=> groupSinkRun == 7'h00)
        else $error("group switch acted with per-sink enable");
    a_auto_level: assert property (@(posedge mclk) disable iff (clrRst)
        autoOn |=> cfg_r[4:3] == $past(autoLvl))
        else $error("auto level not applied");
    a_flag_sticky: assert property (@(posedge mclk) disable iff (clrRst)
        (flags[0] && !clrVec[0]) |=> flags[0])
        else $error("flag lost without clear");
    a_flag_set: assert property (@(posedge mclk) disable iff (clrRst)
        setVec[4] |=> flags[4])
        else $error("short flag not set");
    a_irq_gate: assert property (@(posedge mclk) disable iff (clrRst)
        (!pending && !$past(pending)) |=> hostIntN)
        else $error("interrupt without enabled flag");
    a_irq_raise: assert property (@(posedge mclk) disable iff (clrRst)
        (pending && !relBusy && irqState_r == ldm_pkg::IRQ_IDLE)
        |=> !hostIntN)
        else $error("enabled flag did not raise interrupt");

    sequence s_status_read;
        hostReq.rdEn && hostReq.addr == ldm_pkg::ADDR_STATUS;
    endsequence

    sequence s_mode_write;
        hostReq.wrEn && hostReq.addr == ldm_pkg::ADDR_MODE;
    endsequence

    a_status_reserved: assert property (@(posedge mclk) disable iff (clrRst)
        s_status_read |=> rdata[7:5] == 3'h0)
        else $error("reserved status bits not zero");
    a_mode_reserved: assert property (@(posedge mclk) disable iff (clrRst)
        s_mode_write |=> !mode_r[7])
        else $error("reserved mode bit stored");
    a_backlight_gate: assert property (@(posedge mclk) disable iff (clrRst)
        1'b1 |=> backlightRun == ($past(mode_r[ldm_pkg::BIT_BL_ON])
                                & $past(mode_r[ldm_pkg::BIT_ACTIVE])))
        else $error("backlight run does not follow enable and mode");
    a_sink_follow: assert property (@(posedge mclk) disable iff (clrRst)
        1'b1 |=> diodeIndependent == $past(sink_r[6:0]))
        else $error("sink assignment not applied");
    a_sensor_route: assert property (@(posedge mclk) disable iff (clrRst)
        1'b1 |=> sensorSourceSelect == $past(cfg_r[ldm_pkg::BIT_SRC_SEL])
            && diode6Disable == $past(cfg_r[ldm_pkg::BIT_B_PRESENT]))
        else $error("sensor routing not applied");
endmodule : ldm_regs

//--- dv/ldm_host_model.sv
// host side model driving register reads and writes
`timescale 1ns/1ps
module ldm_host_model
(
    input  wire logic             mclk,
    output ldm_pkg::ldm_hostreq_s hostReq
);
    // ----------------------------------------------------------------
    // one strobe per access, held over exactly one rising edge
    // ----------------------------------------------------------------
    initial hostReq = '0;

    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge mclk);
        hostReq = '{wrEn: w, rdEn: !w, addr: a, wdata: d};
        @(negedge mclk);
        hostReq = '0;
    endtask : access
endmodule : ldm_host_model

//--- dv/led_driver_mode_interrupt_config_regs_tb_top.sv
// self-checking bench of the mode, interrupt and config registers
`timescale 1ns/1ps
module led_driver_mode_interrupt_config_regs_tb_top;
    logic                  mclk;
    logic                  reset;
    logic                  uvloEvt;
    logic                  dimTimeout;
    ldm_pkg::ldm_hostreq_s hostReq;
    ldm_pkg::ldm_events_s  events;
    logic                  offOn, darkOn, offRes, darkRes;
    logic [6:0]            perSinkEnable;
    logic                  ledsAllOff, pumpNeedUp, pumpCanDown;
    logic [7:0]            rdata;
    logic                  hostIntN, activeNotSleep, backlightRun;
    logic                  dimRun, pumpUp, pumpDown, fadeOverride;
    logic [6:0]            groupSinkRun, diodeIndependent;
    logic                  srcSel, bPres, d6Dis;
    logic [1:0]            brightnessLevel, transferLaw;
    logic                  rdSeen;
    logic [7:0]            expQ[$];
    int                    n_mismatch;
    int                    n_compared;
    int                    seed;
    logic [31:0]           v;

    ldm_host_model host_u (.mclk, .hostReq);

    ldm_regs dut_u
    (
        .mclk, .reset, .uvloEvt, .hostReq, .rdata, .events, .dimTimeout,
        .officeLevelCompareOn(offOn), .darkLevelCompareOn(darkOn),
        .officeLevelCompareResult(offRes),
        .darkLevelCompareResult(darkRes),
        .perSinkEnable, .ledsAllOff, .pumpNeedUp, .pumpCanDown, .hostIntN,
        .activeNotSleep, .backlightRun, .dimRun, .pumpUp, .pumpDown,
        .groupSinkRun, .diodeIndependent, .sensorSourceSelect(srcSel),
        .sensorBPresent(bPres), .diode6Disable(d6Dis), .brightnessLevel,
        .transferLaw, .fadeOverride
    );

    // ----------------------------------------------------------------
    // clock, compare and report
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // expected read results are queued by rd and checked here
    always @(posedge mclk) rdSeen <= hostReq.rdEn;
    always @(negedge mclk)
    begin
        if (rdSeen === 1'b1 && expQ.size() > 0)
            chk(rdata, expQ.pop_front());
    end

    initial
    begin
        #(25ns * 20000);
        n_mismatch++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // stimulus helpers
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask : rd

    task automatic settle;
        repeat (3) @(negedge mclk);
    endtask : settle

    task automatic pulse(input logic [4:0] e);
        events = e;
        @(negedge mclk);
        events = '0;
    endtask : pulse

    task automatic waitInt(input logic lvl);
        int k;
        k = 0;
        while (hostIntN !== lvl && k < 40)
        begin
            @(negedge mclk);
            k++;
        end
        chk(hostIntN, lvl);
        if (hostIntN !== lvl)
            end_sim();
    endtask : waitInt

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        seed = 89;
        reset = 1'b1;
        uvloEvt = 1'b0;
        dimTimeout = 1'b0;
        events = '0;
        {offOn, darkOn, offRes, darkRes} = 4'h0;
        perSinkEnable = 7'h00;
        {ledsAllOff, pumpNeedUp, pumpCanDown} = 3'h0;
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        for (int a = 1; a <= 6; a++) rd(8'(a), 8'h00);
        chk(hostIntN, 8'h01);
        wr(ldm_pkg::ADDR_CFG, 8'hff);
        wr(ldm_pkg::ADDR_SINK, 8'hff);
        wr(ldm_pkg::ADDR_IEN, 8'hff);
        wr(ldm_pkg::ADDR_STATUS, 8'hff);
        wr(ldm_pkg::ADDR_MODE, 8'hbf);
        rd(ldm_pkg::ADDR_MODE, 8'h3f);
        rd(ldm_pkg::ADDR_STATUS, 8'h00);
        rd(ldm_pkg::ADDR_IEN, 8'h1f);
        rd(ldm_pkg::ADDR_CFG, 8'h7f);
        rd(ldm_pkg::ADDR_SINK, 8'h7f);
        settle();
        chk(activeNotSleep, 8'h01);
        chk({backlightRun, dimRun}, 8'h03);
        chk(groupSinkRun, 8'h7f);
        chk(diodeIndependent, 8'h7f);
        chk({srcSel, bPres, d6Dis}, 8'h07);
        chk({brightnessLevel, transferLaw}, 8'h0f);
        chk(fadeOverride, 8'h01);
        perSinkEnable = 7'h01;
        {pumpNeedUp, pumpCanDown} = 2'h3;
        settle();
        chk(groupSinkRun, 8'h00);
        chk({pumpUp, pumpDown}, 8'h02);
        ledsAllOff = 1'b1;
        perSinkEnable = 7'h00;
        settle();
        chk(pumpDown, 8'h01);
        ledsAllOff = 1'b0;
        wr(ldm_pkg::ADDR_MODE, 8'h37);
        settle();
        chk(pumpDown, 8'h01);
        wr(ldm_pkg::ADDR_MODE, 8'h11);
        settle();
        chk({activeNotSleep, backlightRun, dimRun}, 8'h00);
        wr(ldm_pkg::ADDR_MODE, 8'h30);
        settle();
        chk({backlightRun, dimRun}, 8'h00);
        wr(ldm_pkg::ADDR_MODE, 8'h21);
        dimTimeout = 1'b1;
        @(negedge mclk);
        dimTimeout = 1'b0;
        rd(ldm_pkg::ADDR_MODE, 8'h31);
        settle();
        chk(dimRun, 8'h01);
        wr(ldm_pkg::ADDR_CFG, 8'h00);
        wr(ldm_pkg::ADDR_MODE, 8'h23);
        {offOn, darkOn, offRes, darkRes} = 4'hf;
        settle();
        chk(brightnessLevel, ldm_pkg::LVL_DARK);
        rd(ldm_pkg::ADDR_CFG, 8'h10);
        darkRes = 1'b0;
        settle();
        chk(brightnessLevel, ldm_pkg::LVL_OFFICE);
        offRes = 1'b0;
        settle();
        chk(brightnessLevel, ldm_pkg::LVL_DAY);
        {offOn, darkOn} = 2'h0;
        wr(ldm_pkg::ADDR_CFG, 8'h18);
        settle();
        chk(brightnessLevel, 8'h03);
        wr(ldm_pkg::ADDR_IEN, 8'h00);
        wr(ldm_pkg::ADDR_MODE, 8'h20);
        for (int i = 0; i < 5; i++)
        begin
            pulse(5'(1 << i));
            rd(ldm_pkg::ADDR_STATUS, 8'(1 << i));
            wr(ldm_pkg::ADDR_STATUS, ~8'(1 << i));
            rd(ldm_pkg::ADDR_STATUS, 8'(1 << i));
            chk(hostIntN, 8'h01);
            wr(ldm_pkg::ADDR_STATUS, 8'(1 << i));
            rd(ldm_pkg::ADDR_STATUS, 8'h00);
        end
        wr(ldm_pkg::ADDR_IEN, 8'h1f);
        events.overheatEvt = 1'b1;
        waitInt(1'b0);
        wr(ldm_pkg::ADDR_STATUS, 8'h08);
        for (int i = 0; i < 20; i++)
        begin
            @(negedge mclk);
            chk(hostIntN, 8'h00);
        end
        repeat (20) @(negedge mclk);
        chk(hostIntN, 8'h00);
        wr(ldm_pkg::ADDR_MODE, 8'h60);
        wr(ldm_pkg::ADDR_STATUS, 8'h08);
        repeat (3) @(negedge mclk);
        chk(hostIntN, 8'h01);
        repeat (ldm_pkg::RELEASE_CYC - 10) @(negedge mclk);
        chk(hostIntN, 8'h01);
        waitInt(1'b0);
        events = '0;
        wr(ldm_pkg::ADDR_STATUS, 8'h08);
        rd(ldm_pkg::ADDR_STATUS, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            wr(ldm_pkg::ADDR_SINK, v[7:0]);
            rd(ldm_pkg::ADDR_SINK, v[7:0] & 8'h7f);
            settle();
            chk(diodeIndependent, v[6:0]);
        end
        uvloEvt = 1'b1;
        @(negedge mclk);
        uvloEvt = 1'b0;
        for (int a = 1; a <= 5; a++) rd(8'(a), 8'h00);
        settle();
        if (expQ.size() != 0)
            chk(8'(expQ.size()), 8'h00);
        end_sim();
    end
endmodule : led_driver_mode_interrupt_config_regs_tb_top
